// ### aeis_defect_mon.sv
// Receive defect detectors: out of frame, all-ones alarm and remote alarm
`timescale 1ns/1ns
`include "aeis_map.svh"
module aeis_defect_mon
   import aeis_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       bit_valid_i,
   input  wire logic       rx_bit_i,
   input  wire logic       frame_start_i,
   input  wire logic       fas_frame_i,
   input  wire logic       fas_error_i,
   input  wire logic       a_bit_i,
   input  wire logic [2:0] frame_loss_threshold_i,
   output logic            out_of_frame_o,
   output logic            all_ones_alarm_o,
   output logic            remote_alarm_o
);
   logic [2:0] fas_err_cnt_reg;
   logic [8:0] zero_cnt_reg;
   logic [8:0] prev_zero_reg;
   logic [1:0] ones_frames_reg;
   logic       last_a_reg;
   logic       a_valid_reg;

   // Errored alignment patterns counted back to back; a good one restarts the count
   wire        fas_seen  = frame_start_i && fas_frame_i;
   wire        fas_hit   = fas_seen && fas_error_i
                           && (fas_err_cnt_reg + 3'h1 >= frame_loss_threshold_i);
   wire        nfas_seen = frame_start_i && !fas_frame_i;
   // Zeros over two frames; a frame with no zeros counts as all-ones
   wire [9:0]  zeros_2f  = {1'b0, zero_cnt_reg} + {1'b0, prev_zero_reg};

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         fas_err_cnt_reg <= 3'h0;
         out_of_frame_o  <= 1'b0;
      end else if (fas_seen) begin
         if (!fas_error_i) begin
            fas_err_cnt_reg <= 3'h0;
            out_of_frame_o  <= 1'b0;
         end else if (fas_hit) begin
            out_of_frame_o  <= 1'b1;
         end else begin
            fas_err_cnt_reg <= fas_err_cnt_reg + 3'h1;
         end
      end
   end

   // All-ones alarm: two whole frames of ones sets, over two zeros in two frames clears
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         zero_cnt_reg     <= 9'h000;
         prev_zero_reg    <= 9'h000;
         ones_frames_reg  <= 2'h0;
         all_ones_alarm_o <= 1'b0;
      end else if (frame_start_i) begin
         prev_zero_reg <= zero_cnt_reg;
         zero_cnt_reg  <= 9'h000;
         if (zero_cnt_reg == 9'h000) begin
            if (ones_frames_reg + 2'h1 >= 2'(`AEIS_AIS_FRAMES))
               all_ones_alarm_o <= 1'b1;
            else
               ones_frames_reg <= ones_frames_reg + 2'h1;
         end else begin
            ones_frames_reg <= 2'h0;
         end
         if (zeros_2f > 10'(`AEIS_AIS_ZERO_LIMIT))
            all_ones_alarm_o <= 1'b0;
      end else if (bit_valid_i && !rx_bit_i && zero_cnt_reg != 9'h1FF) begin
         zero_cnt_reg <= zero_cnt_reg + 9'h001;
      end
   end

   // Remote alarm follows A when two consecutive non-alignment frames agree
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         last_a_reg     <= 1'b0;
         a_valid_reg    <= 1'b0;
         remote_alarm_o <= 1'b0;
      end else if (nfas_seen) begin
         last_a_reg  <= a_bit_i;
         a_valid_reg <= 1'b1;
         if (a_valid_reg && last_a_reg == a_bit_i)
            remote_alarm_o <= a_bit_i;
      end
   end
endmodule

// ### aeis_host.sv
// Host model driving the parallel register port
`timescale 1ns/1ns
module aeis_host (
   input  wire logic        clk_i,
   output logic      [15:0] addr_o,
   output logic      [7:0]  wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   input  wire logic [7:0]  rdata_i
);
   initial begin
      addr_o = 16'h0000;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // One-cycle write strobe; stale data is inverted so nothing leans on it
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   // Read data is taken once the answering edge has passed
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      d = rdata_i;
   endtask
endmodule

// ### aeis_map.svh
// Register offsets, bit positions, reset values and timing counts of the alarm/error status block
`ifndef AEIS_MAP_SVH
`define AEIS_MAP_SVH
`define AEIS_STATUS_ADDR      16'h0B02
`define AEIS_FRAMING_ADDR     16'h010B
`define AEIS_ENABLE_ADDR      16'h0B03
`define AEIS_BLKEN_ADDR       16'h0B00
`define AEIS_BIT_VIOL         3
`define AEIS_BIT_LOSS         2
`define AEIS_BIT_AIS          1
`define AEIS_BIT_YEL          0
`define AEIS_BIT_BLKEN        1
`define AEIS_THRESH_RESET     3'h3
`define AEIS_STATUS_RESET     4'h0
`define AEIS_FRAME_BITS       256
`define AEIS_NFAS_FRAMES      2
`define AEIS_AIS_ZERO_LIMIT   2
`define AEIS_AIS_FRAMES       2
`endif

// ### aeis_pkg.sv
// Types shared by the alarm/error status block
package aeis_pkg;
   typedef logic [3:0] aeis_flags_t;
   typedef enum logic [1:0] {
      AEIS_HUNT  = 2'b00,
      AEIS_SYNC  = 2'b01,
      AEIS_LOST  = 2'b10
   } aeis_frame_state_t;
endpackage

// ### aeis_status.sv
// Alarm and error interrupt status register with change detection and interrupt gating
//
// What this block does
// - Line code violation sets status bit 3
// - Out-of-frame declare or clear sets bit 2
// - Out-of-frame after threshold errored alignment patterns
// - All-ones alarm change sets bit 1
// - Remote alarm change sets bit 0
// - Flags reset zero, cleared by host read
// - Only enabled flags drive the interrupt
// - Status register sits at 0x0B02
// - All-ones declared after two frames, cleared by zeros
// - Remote alarm follows A over two frames
// - Block enable gates every alarm interrupt
`timescale 1ns/1ns
`include "aeis_map.svh"
module aeis_status
   import aeis_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        line_code_violation_i,
   input  wire logic        bit_valid_i,
   input  wire logic        rx_bit_i,
   input  wire logic        frame_start_i,
   input  wire logic        fas_frame_i,
   input  wire logic        fas_error_i,
   input  wire logic        a_bit_i,
   output logic             out_of_frame_o,
   output logic             all_ones_alarm_o,
   output logic             remote_alarm_o,
   output logic             irq_o
);
   import aeis_pkg::*;

   // Register state
   aeis_flags_t flags_reg;
   aeis_flags_t enable_reg;
   logic [2:0]  frame_loss_threshold_reg;
   logic        alarm_block_irq_enable_reg;
   logic [2:0]  defect_d_reg;

   // Decode and next-state nets
   aeis_flags_t flags_next;
   aeis_flags_t events;
   aeis_flags_t enable_next;
   aeis_flags_t pending_w;
   logic [2:0]  frame_loss_threshold_next;
   logic        alarm_block_irq_enable_next;
   logic [2:0]  defect_w;
   logic [3:0]  sel_w;
   logic [7:0]  rdata_next;
   logic        irq_next;
   logic        status_read;
   logic        loss_w;
   logic        ones_w;
   logic        remote_w;

   // One-hot register select, bit order: status, enables, framing, block enable
   // Decoded once so the read clear and the read image always agree
   function automatic logic [3:0] reg_select(input logic [15:0] a);
      logic [3:0] s;
      s    = 4'h0;
      s[0] = (a == `AEIS_STATUS_ADDR);
      s[1] = (a == `AEIS_ENABLE_ADDR);
      s[2] = (a == `AEIS_FRAMING_ADDR);
      s[3] = (a == `AEIS_BLKEN_ADDR);
      return s;
   endfunction

   // Status image: live all-ones state in bit 6, change flags in the low nibble
   function automatic logic [7:0] status_image(input aeis_flags_t f, input logic ones);
      return {1'b0, ones, 2'h0, f};
   endfunction

   // Read image of any register; unmapped space reads as zero
   function automatic logic [7:0] read_image(
      input logic [3:0]  s,
      input aeis_flags_t f,
      input aeis_flags_t en,
      input logic [2:0]  thr,
      input logic        blk,
      input logic        ones,
      input logic        remote
   );
      logic [7:0] v;
      v = 8'h00;
      if (s[0])
         v = status_image(f, ones);
      else if (s[1])
         v = {remote, 3'h0, en};
      else if (s[2])
         v = {5'h00, thr};
      else if (s[3])
         v = {6'h00, blk, 1'b0};
      return v;
   endfunction

   // Defect detectors run on the same clock as the register port
   aeis_defect_mon u_mon (
      .clk_i                  (clk_i),
      .reset_n_i              (reset_n_i),
      .bit_valid_i            (bit_valid_i),
      .rx_bit_i               (rx_bit_i),
      .frame_start_i          (frame_start_i),
      .fas_frame_i            (fas_frame_i),
      .fas_error_i            (fas_error_i),
      .a_bit_i                (a_bit_i),
      .frame_loss_threshold_i (frame_loss_threshold_reg),
      .out_of_frame_o         (loss_w),
      .all_ones_alarm_o       (ones_w),
      .remote_alarm_o         (remote_w)
   );

   // Defect levels go out as they are and feed the change detectors
   assign out_of_frame_o   = loss_w;
   assign all_ones_alarm_o = ones_w;
   assign remote_alarm_o   = remote_w;
   assign defect_w         = {loss_w, ones_w, remote_w}; // Lines up with flag bits 2 to 0

   // Address decode shared by the write and read paths
   assign sel_w       = reg_select(addr_i);
   assign status_read = rd_i && sel_w[0];

   // Each high cycle of the violation input is one event by itself
   assign events[`AEIS_BIT_VIOL] = line_code_violation_i;

   // Either edge of a defect level counts as one change event
   // Defect bit k maps onto flag bit k, so one loop serves all three
   for (genvar k = 0; k < 3; k++) begin : g_change
      always_ff @(posedge clk_i) begin
         if (!reset_n_i) begin
            defect_d_reg[k] <= 1'b0;
         end else begin
            defect_d_reg[k] <= defect_w[k];
         end
      end
      assign events[k] = defect_w[k] ^ defect_d_reg[k];
   end

   // Read clears, but an event in the same cycle still lands: the set wins
   assign flags_next = (status_read ? 4'h0 : flags_reg) | events;

   // Sticky change flags; the status register itself ignores writes
   // A flag stays set until a status read, however old the event is
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         flags_reg <= `AEIS_STATUS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Host write decode for the three writable registers
   // Only a strobe with a matching address changes a register
   assign enable_next = (wr_i && sel_w[1]) ? wdata_i[3:0] : enable_reg;
   assign alarm_block_irq_enable_next =
      (wr_i && sel_w[3]) ? wdata_i[`AEIS_BIT_BLKEN] : alarm_block_irq_enable_reg;
   assign frame_loss_threshold_next =
      (wr_i && sel_w[2]) ? wdata_i[2:0] : frame_loss_threshold_reg;

   // Per-source interrupt enables
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         enable_reg <= 4'h0;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // Block-level enable; cleared, it silences every source at once
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         alarm_block_irq_enable_reg <= 1'b0;
      end else begin
         alarm_block_irq_enable_reg <= alarm_block_irq_enable_next;
      end
   end

   // Loss threshold; zero acts like one since the first errored pattern meets it
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         frame_loss_threshold_reg <= `AEIS_THRESH_RESET;
      end else begin
         frame_loss_threshold_reg <= frame_loss_threshold_next;
      end
   end

   // Read data holds until the next read, so the host may sample it late
   assign rdata_next = rd_i ? read_image(sel_w, flags_reg, enable_reg,
                                         frame_loss_threshold_reg,
                                         alarm_block_irq_enable_reg, ones_w, remote_w)
                            : rdata_o;

   // Read data register
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rdata_next;
      end
   end

   // Enabled flags first, then the block enable over all of them
   assign pending_w = flags_next & enable_reg;
   assign irq_next  = alarm_block_irq_enable_reg && (|pending_w);

   // Registered so the pin never glitches while flags settle
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_next;
      end
   end
endmodule

// ### aeis_status_bench.sv
// Self-checking bench for the alarm/error status block
`timescale 1ns/1ns
module aeis_status_bench;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        viol = 1'b0, frm = 1'b0, ff = 1'b0, fe = 1'b0, ab = 1'b0, rxb = 1'b0;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, got;
   logic        wr, rd, lost, ones, remote, irq;
   logic [31:0] seed = 32'h94125801;
   int          failures = 0, n_compared = 0;
   initial forever #20 clk_i = ~clk_i;
   aeis_host host (.clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   aeis_status dut (.clk_i, .reset_n_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .line_code_violation_i(viol), .bit_valid_i(1'b1), .rx_bit_i(rxb),
      .frame_start_i(frm), .fas_frame_i(ff), .fas_error_i(fe), .a_bit_i(ab),
      .out_of_frame_o(lost), .all_ones_alarm_o(ones), .remote_alarm_o(remote), .irq_o(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Status image: live all-ones state in bit 6, change flags low
   function automatic logic [7:0] exp_st(input logic [3:0] f, input logic a);
      return {1'b0, a, 2'h0, f};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      n_compared++;
      if (seen !== want) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One frame boundary pulse followed by a few received bits
   task automatic frame(input logic f, input logic e, input logic a);
      @(negedge clk_i);
      frm = 1'b1;
      ff = f;
      fe = e;
      ab = a;
      @(negedge clk_i);
      frm = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask
   initial begin
      #(40 * 3000);
      failures++;
      results;
   end
   initial begin
      repeat (10) @(negedge clk_i);
      reset_n_i = 1'b1;
      host.rd(16'h0B02, got);
      check(got, 8'h00);
      host.rd({4'hC, seed[11:0]}, got);
      check(got, 8'h00);
      $display("reset and unmapped read test done");
      // Violations under random source and block gates; back-to-back reads clear
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         host.wr(16'h0B03, {4'h0, seed[3], 3'h7});
         host.wr(16'h0B00, {6'h00, seed[4], 1'b0});
         @(negedge clk_i) viol = 1'b1;
         @(negedge clk_i) viol = 1'b0;
         check({7'h00, irq}, {7'h00, seed[3] & seed[4]});
         host.rd(16'h0B02, got);
         check(got, exp_st(4'h8, 1'b0));
         host.rd(16'h0B02, got);
         check(got, exp_st(4'h0, 1'b0));
      end
      $display("violation and gating test done");
      // Remote alarm, then frame loss at threshold 2 and its recovery
      host.wr(16'h010B, 8'h02);
      repeat (2) begin
         frame(1'b1, 1'b0, 1'b0);
         frame(1'b0, 1'b0, 1'b1);
      end
      check({7'h00, remote}, 8'h01);
      host.rd(16'h0B02, got);
      check(got, exp_st(4'h1, 1'b0));
      frame(1'b1, 1'b1, 1'b0);
      frame(1'b0, 1'b0, 1'b1);
      check({7'h00, lost}, 8'h00);
      frame(1'b1, 1'b1, 1'b0);
      check({7'h00, lost}, 8'h01);
      host.rd(16'h0B02, got);
      check(got, exp_st(4'h4, 1'b0));
      frame(1'b1, 1'b0, 1'b0);
      host.rd(16'h0B02, got);
      check(got, exp_st(4'h4, 1'b0));
      $display("remote alarm and frame loss test done");
      // All-ones stream declares, zeros clear
      rxb = 1'b1;
      repeat (3) frame(1'b1, 1'b0, 1'b1);
      host.rd(16'h0B02, got);
      check(got, exp_st(4'h2, 1'b1));
      rxb = 1'b0;
      repeat (2) frame(1'b1, 1'b0, 1'b1);
      host.rd(16'h0B02, got);
      check(got, exp_st(4'h2, 1'b0));
      $display("all-ones alarm test done");
      results;
   end
endmodule
bind aeis_status aeis_status_checker chk (.*);

// ### aeis_status_checker.sv
// Port-level assertions for the alarm/error status block
`timescale 1ns/1ns
`include "aeis_map.svh"
module aeis_status_checker (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  rdata_o,
   input  wire logic        line_code_violation_i,
   input  wire logic        out_of_frame_o,
   input  wire logic        all_ones_alarm_o,
   input  wire logic        remote_alarm_o,
   input  wire logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Read decodes; stray reads are aimed at an unused 0xCxxx area
   wire        status_rd = rd_i && addr_i == `AEIS_STATUS_ADDR;
   wire        stray_rd  = rd_i && addr_i[15:12] == 4'hC;
   wire  [2:0] dfx       = {out_of_frame_o, all_ones_alarm_o, remote_alarm_o};
   logic [3:0] pend;
   // Flags the host should see: any violation or defect edge since the last status read
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pend <= 4'h0;
      end else begin
         pend <= (status_rd ? 4'h0 : pend) | {line_code_violation_i, dfx ^ $past(dfx)};
      end
   end
   // No new event may land while a read is clearing
   sequence qt;
      !line_code_violation_i && $stable(dfx);
   endsequence
   a_flag_viol: assert property (status_rd |=> rdata_o[3] == $past(pend[3]))
      else $error("violation flag wrong");
   a_flag_loss: assert property (status_rd |=> rdata_o[2] == $past(pend[2]))
      else $error("frame loss change flag wrong");
   a_flag_ones: assert property (status_rd |=> rdata_o[1] == $past(pend[1]))
      else $error("all-ones change flag wrong");
   a_flag_remote: assert property (status_rd |=> rdata_o[0] == $past(pend[0]))
      else $error("remote alarm change flag wrong");
   a_read_clears: assert property (status_rd ##0 qt ##1 qt ##1 status_rd ##0 qt
      |=> rdata_o[3:0] == 4'h0) else $error("flags survived a read");
   a_irq_drops: assert property (status_rd ##0 qt |=> !irq_o)
      else $error("interrupt held after read");
   a_irq_cause: assert property ($rose(irq_o) |-> $past(line_code_violation_i) ||
      $past(dfx, 2) != $past(dfx) || $past(wr_i) || $past(wr_i, 2))
      else $error("interrupt without cause");
   a_status_layout: assert property (status_rd |=> rdata_o[7] == 1'b0 &&
      rdata_o[5:4] == 2'h0 && rdata_o[6] == $past(all_ones_alarm_o))
      else $error("status layout wrong");
   a_stray_zero: assert property (stray_rd |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule
